/* design/tcc_pkg.sv */
// tcc_pkg: register indices, field positions and codes for the timer
// assumes byte-wide registers placed one per aligned 32-bit bus word
package tcc_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int SW = 4;
	localparam int IW = 6;
	localparam int IX_LSB = 2;
	localparam int CW = 16;
	localparam int BW = 8;
	localparam int CH_LO = 2;
	localparam int CH_HI = 7;
	localparam int NCH = 6;
	localparam int PRW = 3;
	localparam int DIVW = 7;
	localparam int D64W = 6;
	// register indices, byte address is four times the index
	localparam logic [IW-1:0] IX_DIR_SEL = 6'h00;
	localparam logic [IW-1:0] IX_FORCE = 6'h01;
	localparam logic [IW-1:0] IX_C7_MASK = 6'h02;
	localparam logic [IW-1:0] IX_C7_DATA = 6'h03;
	localparam logic [IW-1:0] IX_CNT_HI = 6'h04;
	localparam logic [IW-1:0] IX_CNT_LO = 6'h05;
	localparam logic [IW-1:0] IX_SYS1 = 6'h06;
	localparam logic [IW-1:0] IX_OVF_TGL = 6'h07;
	localparam logic [IW-1:0] IX_OACT_HI = 6'h08;
	localparam logic [IW-1:0] IX_OACT_LO = 6'h09;
	localparam logic [IW-1:0] IX_EDGE_HI = 6'h0a;
	localparam logic [IW-1:0] IX_EDGE_LO = 6'h0b;
	localparam logic [IW-1:0] IX_IRQ_EN = 6'h0c;
	localparam logic [IW-1:0] IX_SYS2 = 6'h0d;
	localparam logic [IW-1:0] IX_CH_FLG = 6'h0e;
	localparam logic [IW-1:0] IX_OVF_FLG = 6'h0f;
	localparam logic [IW-1:0] IX_TC_FIRST = 6'h14;
	localparam logic [IW-1:0] IX_TC_LAST = 6'h1f;
	localparam logic [IW-1:0] IX_ACC_CTL = 6'h20;
	localparam logic [IW-1:0] IX_ACC_FLG = 6'h21;
	localparam logic [IW-1:0] IX_ACC_HI = 6'h22;
	localparam logic [IW-1:0] IX_ACC_LO = 6'h23;
	localparam int TC_BASE = 'h10;
	// field positions
	localparam int B_TEN = 7;
	localparam int B_WAI = 6;
	localparam int B_FRZ = 5;
	localparam int B_TOI = 7;
	localparam int B_TCRE = 3;
	localparam int B_TOF = 7;
	localparam int B_PAEN = 6;
	localparam int B_PAMOD = 5;
	localparam int B_PEDGE = 4;
	localparam int B_PAOVI = 1;
	localparam int B_PAI = 0;
	localparam int B_RISE = 0;
	localparam int B_FALL = 1;
	// writable bit masks and reset values
	localparam logic [BW-1:0] CH_MASK = 8'hfc;
	localparam logic [BW-1:0] LO2_MASK = 8'hf0;
	localparam logic [BW-1:0] SYS1_MASK = 8'hf0;
	localparam logic [BW-1:0] SYS2_MASK = 8'h8f;
	localparam logic [BW-1:0] ACC_MASK = 8'h7f;
	localparam logic [BW-1:0] TOF_MASK = 8'h80;
	localparam logic [BW-1:0] ACCF_MASK = 8'h03;
	localparam logic [BW-1:0] RST8 = 8'h00;
	localparam logic [CW-1:0] CNT_RST = 16'h0000;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;
	localparam logic [CW-1:0] CNT_MAX = 16'hffff;
	// output actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TGL = 2'h1;
	localparam logic [1:0] ACT_CLR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/tcc_sync.sv */
// tcc_sync: two-flop synchroniser for the channel pins
// assumes inputs asynchronous to aclk
`timescale 1ns/1ps
module tcc_sync
	import tcc_pkg::*;
#(
	parameter int W = NCH
) (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// data
	input logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			q <= '0;
		end else begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule

/* design/tcc_presc.sv */
// tcc_presc: seven-stage prescaler giving count ticks and a divide-by-64 tick
// assumes en already folds in every halt condition
`timescale 1ns/1ps
module tcc_presc
	import tcc_pkg::*;
(
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// control
	input logic en,
	input logic [PRW-1:0] pr,
	// ticks
	output logic tick,
	output logic div64
);
	logic [DIVW-1:0] div_q;
	logic [DIVW-1:0] msk;

	assign msk = DIVW'((1 << pr) - 1);
	assign tick = en & ((div_q & msk) == msk);
	assign div64 = en & (&div_q[D64W-1:0]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '0;
		end else if (en) begin
			div_q <= div_q + DIVW'(1);
		end
	end
endmodule

/* design/tcc_top.sv */
// tcc_top: 16-bit timer, six capture/compare channels, pulse accumulator
// assumes an AXI4-Lite master on aclk; mode inputs come from logic on aclk
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Function
// R01: stop mode halts counter, prescaler, channels and accumulator entirely.
// R02: in freeze the counter runs unless the freeze halt bit is one.
// R03: in wait the counters run unless the wait halt bit is one.
// R04: normally the counter runs while the timer enable bit is one.
// R05: channel 7 pin serves channel 7 or feeds the pulse accumulator.
// R06: direction bit zero gives input capture, one gives output compare.
// R07: register address is base plus fixed offset; decode uses offset only.
// R08: eight pins; channels 2 to 6 each use their own pin.
// R09: offsets 0x10-0x13 and 0x24-0x2f and undefined bits do nothing.
// R10: the main counter is a 16-bit up counter after a 7-stage prescaler.
// R11: 16-bit values are meant for word access; byte halves may disagree.
// R12: everything runs on the bus clock and resets to power-on state.
module tcc_top
	import tcc_pkg::*;
(
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// axi4-lite write
	input logic [AW-1:0] s_axi_awaddr,
	input logic [2:0] s_axi_awprot,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [DW-1:0] s_axi_wdata,
	input logic [SW-1:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	// axi4-lite read
	input logic [AW-1:0] s_axi_araddr,
	input logic [2:0] s_axi_arprot,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	// system modes
	input logic stop_mode,
	input logic freeze_mode,
	input logic wait_mode,
	input logic test_mode,
	// timer pins
	input logic [7:0] ioc_in,
	output logic [7:0] ioc_out,
	output logic [7:0] ioc_oe_n,
	// interrupt
	output logic irq
);
	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [IW-1:0] wix_q;
	logic [BW-1:0] wb_q;
	logic wstb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [BW-1:0] rdata_q;
	logic [BW-1:0] dir_q, c7m_q, c7d_q, sys1_q, tov_q, oah_q, oal_q;
	logic [BW-1:0] edh_q, edl_q, ien_q, sys2_q, accc_q;
	logic [BW-1:0] chflg_q, accf_q, lob_q;
	logic [IW-1:0] lob_ix_q;
	logic lob_v_q, tof_q, tick_q, irq_q;
	logic [CW-1:0] cnt_q, acc_q;
	logic [CW-1:0] tc_q [CH_LO:CH_HI];
	logic [CH_HI:CH_LO] pin_s, pin_p_q, pin_q;
	logic [IW-1:0] rix, lix;
	logic wr_go, wr_en, rd_go, frc_wr, run, act, tick, div64, ovf, c7ev;
	logic pa_on, sel_edge, pa_inc;
	logic [2*BW-1:0] oact, edg;
	logic [BW-1:0] ch_set8;
	wire [CH_HI:CH_LO] cmp, frc, cap, rise, fall, pin_d;

	// bus slave: one write and one read at a time
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = {{(DW - BW){1'b0}}, rdata_q};
	assign rix = s_axi_araddr[IX_LSB +: IW]; // [R07]
	assign lix = rix + IW'(1);
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign wr_en = wr_go && wstb_q && mapped(wix_q);
	assign rd_go = s_axi_arvalid && !rvalid_q;
	assign frc_wr = wr_en && (wix_q == IX_FORCE);

	function automatic logic mapped(input logic [IW-1:0] ix);
		mapped = (ix <= IX_OVF_FLG) || (ix >= IX_TC_FIRST && ix <= IX_ACC_LO); // [R09]
	endfunction

	function automatic logic is_hi(input logic [IW-1:0] ix);
		is_hi = (ix == IX_CNT_HI) || (ix == IX_ACC_HI) ||
			(ix >= IX_TC_FIRST && ix <= IX_TC_LAST && !ix[0]);
	endfunction

	function automatic logic [BW-1:0] rmux(input logic [IW-1:0] ix);
		logic [BW-1:0] v;
		v = RST8;
		case (ix)
			IX_DIR_SEL: v = dir_q;
			IX_C7_MASK: v = c7m_q;
			IX_C7_DATA: v = c7d_q;
			IX_CNT_HI: v = cnt_q[CW-1:BW];
			IX_CNT_LO: v = cnt_q[BW-1:0];
			IX_SYS1: v = sys1_q;
			IX_OVF_TGL: v = tov_q;
			IX_OACT_HI: v = oah_q;
			IX_OACT_LO: v = oal_q;
			IX_EDGE_HI: v = edh_q;
			IX_EDGE_LO: v = edl_q;
			IX_IRQ_EN: v = ien_q;
			IX_SYS2: v = sys2_q;
			IX_CH_FLG: v = chflg_q;
			IX_OVF_FLG: v = {tof_q, 7'h00};
			IX_ACC_CTL: v = accc_q;
			IX_ACC_FLG: v = accf_q;
			IX_ACC_HI: v = acc_q[CW-1:BW];
			IX_ACC_LO: v = acc_q[BW-1:0];
			default: begin
				for (int i = CH_LO; i <= CH_HI; i++) begin
					if (ix == IW'(TC_BASE + 2 * i)) begin
						v = tc_q[i][CW-1:BW];
					end
					if (ix == IW'(TC_BASE + 2 * i + 1)) begin
						v = tc_q[i][BW-1:0];
					end
				end
			end
		endcase
		return v;
	endfunction

	function automatic logic do_act(input logic [1:0] a, input logic p);
		case (a)
			ACT_TGL: do_act = ~p;
			ACT_CLR: do_act = 1'b0;
			ACT_SET: do_act = 1'b1;
			default: do_act = p;
		endcase
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			wix_q <= '0;
			wb_q <= RST8;
			wstb_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				wix_q <= s_axi_awaddr[IX_LSB +: IW];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wb_q <= s_axi_wdata[BW-1:0];
				wstb_q <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(wix_q) ? RESP_OKAY : RESP_SLVERR; // [R09]
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read answer; a high-byte read latches its low byte for the next read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= RST8;
			lob_q <= RST8;
			lob_ix_q <= '0;
			lob_v_q <= 1'b0;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rresp_q <= mapped(rix) ? RESP_OKAY : RESP_SLVERR;
			rdata_q <= (lob_v_q && rix == lob_ix_q) ? lob_q : rmux(rix); // [R11]
			lob_q <= rmux(lix);
			lob_ix_q <= lix;
			lob_v_q <= is_hi(rix); // [R11]
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q <= RST8; // [R12]
			c7m_q <= RST8;
			c7d_q <= RST8;
			sys1_q <= RST8;
			tov_q <= RST8;
			oah_q <= RST8;
			oal_q <= RST8;
			edh_q <= RST8;
			edl_q <= RST8;
			ien_q <= RST8;
			sys2_q <= RST8;
			accc_q <= RST8;
		end else if (wr_en) begin
			case (wix_q)
				IX_DIR_SEL: dir_q <= wb_q & CH_MASK; // [R06]
				IX_C7_MASK: c7m_q <= wb_q & CH_MASK;
				IX_C7_DATA: c7d_q <= wb_q & CH_MASK;
				IX_SYS1: sys1_q <= wb_q & SYS1_MASK;
				IX_OVF_TGL: tov_q <= wb_q & CH_MASK;
				IX_OACT_HI: oah_q <= wb_q;
				IX_OACT_LO: oal_q <= wb_q & LO2_MASK;
				IX_EDGE_HI: edh_q <= wb_q;
				IX_EDGE_LO: edl_q <= wb_q & LO2_MASK;
				IX_IRQ_EN: ien_q <= wb_q & CH_MASK; // [R09]
				IX_SYS2: sys2_q <= wb_q & SYS2_MASK;
				IX_ACC_CTL: accc_q <= wb_q & ACC_MASK;
				default: ;
			endcase
		end
	end

	// mode gating and prescaler
	assign act = !stop_mode; // [R01]
	assign run = sys1_q[B_TEN] && act && // [R04]
		!(freeze_mode && sys1_q[B_FRZ]) && // [R02]
		!(wait_mode && sys1_q[B_WAI]); // [R03]

	tcc_presc u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(run),
		.pr(sys2_q[PRW-1:0]),
		.tick(tick),
		.div64(div64)
	);

	tcc_sync #(.W(NCH)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(ioc_in[CH_HI:CH_LO]),
		.q(pin_s)
	);

	assign ovf = tick && (cnt_q == CNT_MAX);
	assign c7ev = cmp[CH_HI] || frc[CH_HI];

	// main counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= CNT_RST;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick;
			if (cmp[CH_HI] && sys2_q[B_TCRE]) begin
				cnt_q <= CNT_RST;
			end else if (wr_en && test_mode && wix_q == IX_CNT_HI) begin
				cnt_q[CW-1:BW] <= wb_q;
			end else if (wr_en && test_mode && wix_q == IX_CNT_LO) begin
				cnt_q[BW-1:0] <= wb_q;
			end else if (tick) begin
				cnt_q <= cnt_q + CNT_ONE; // [R10]
			end
		end
	end

	// channels
	assign oact = {oah_q, oal_q};
	assign edg = {edh_q, edl_q};
	for (genvar g = CH_LO; g <= CH_HI; g++) begin : g_ch
		logic [1:0] oa, ed;
		assign oa = oact[2 * g +: 2];
		assign ed = edg[2 * g +: 2];
		assign rise[g] = pin_s[g] && !pin_p_q[g];
		assign fall[g] = !pin_s[g] && pin_p_q[g];
		assign cmp[g] = act && tick_q && dir_q[g] && (cnt_q == tc_q[g]); // [R06] [R01]
		assign frc[g] = act && frc_wr && wb_q[g] && dir_q[g]; // [R01]
		assign cap[g] = act && !dir_q[g] && // [R06]
			((ed[B_RISE] && rise[g]) || (ed[B_FALL] && fall[g]));
		assign pin_d[g] = frc[g] ? do_act(oa, pin_q[g]) :
			(c7ev && c7m_q[g]) ? c7d_q[g] :
			cmp[g] ? do_act(oa, pin_q[g]) :
			(ovf && tov_q[g]) ? !pin_q[g] : pin_q[g];
		assign ioc_oe_n[g] = !(dir_q[g] && !(pa_on && g == CH_HI) && // [R05] [R08]
			(oa != ACT_NONE || c7m_q[g] || tov_q[g]));
	end
	assign ioc_oe_n[CH_LO-1:0] = '1;
	assign ioc_out = {pin_q, {CH_LO{1'b0}}};
	assign ch_set8 = {(cmp & ~frc) | cap, {CH_LO{1'b0}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= '0;
			pin_p_q <= '0;
		end else begin
			pin_q <= pin_d; // [R08]
			pin_p_q <= pin_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = CH_LO; i <= CH_HI; i++) begin
				tc_q[i] <= CNT_RST;
			end
		end else begin
			for (int i = CH_LO; i <= CH_HI; i++) begin
				if (cap[i]) begin
					tc_q[i] <= cnt_q;
				end else if (wr_en && wix_q == IW'(TC_BASE + 2 * i)) begin
					tc_q[i][CW-1:BW] <= wb_q;
				end else if (wr_en && wix_q == IW'(TC_BASE + 2 * i + 1)) begin
					tc_q[i][BW-1:0] <= wb_q;
				end
			end
		end
	end

	// pulse accumulator on the channel 7 pin
	assign pa_on = accc_q[B_PAEN] && act && !(wait_mode && sys1_q[B_WAI]); // [R05]
	assign sel_edge = accc_q[B_PEDGE] ? rise[CH_HI] : fall[CH_HI];
	assign pa_inc = pa_on && (accc_q[B_PAMOD] ?
		(div64 && (pin_s[CH_HI] ^ accc_q[B_PEDGE])) : sel_edge);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= CNT_RST;
		end else if (wr_en && wix_q == IX_ACC_HI) begin
			acc_q[CW-1:BW] <= wb_q;
		end else if (wr_en && wix_q == IX_ACC_LO) begin
			acc_q[BW-1:0] <= wb_q;
		end else if (pa_inc) begin
			acc_q <= acc_q + CNT_ONE;
		end
	end

	// sticky flags, write one to clear, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chflg_q <= RST8;
			tof_q <= 1'b0;
			accf_q <= RST8;
		end else begin
			chflg_q <= (chflg_q & ~((wr_en && wix_q == IX_CH_FLG) ? wb_q : RST8)) | ch_set8;
			tof_q <= (tof_q && !(wr_en && wix_q == IX_OVF_FLG && wb_q[B_TOF])) || ovf;
			accf_q <= (accf_q & ~((wr_en && wix_q == IX_ACC_FLG) ? wb_q : RST8)) |
				(BW'({pa_inc && acc_q == CNT_MAX, pa_on && sel_edge}) << B_PAI);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(chflg_q & ien_q) || (tof_q && sys2_q[B_TOI]) ||
				|(accf_q[B_PAOVI:B_PAI] & accc_q[B_PAOVI:B_PAI]);
		end
	end
	assign irq = irq_q;

	stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
		stop_mode && !test_mode |=> $stable(cnt_q) && $stable(pin_q))
		else $error("counter or pins moved in stop mode");
	freeze_halt_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
		freeze_mode && sys1_q[B_FRZ] && !test_mode && !cmp[CH_HI] |=> $stable(cnt_q))
		else $error("counter moved while frozen");
	wait_halt_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
		wait_mode && sys1_q[B_WAI] && !test_mode && !cmp[CH_HI] && !wr_en
		|=> $stable(cnt_q) && $stable(acc_q))
		else $error("counters moved in wait with halt set");
	count_run_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
		run && sys2_q[PRW-1:0] == '0 && !sys2_q[B_TCRE] && !test_mode
		|=> cnt_q == $past(cnt_q) + CNT_ONE)
		else $error("enabled counter did not advance");
	acc_event_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
		pa_on && !accc_q[B_PAMOD] && accc_q[B_PEDGE] && rise[CH_HI] && !wr_en
		|=> acc_q == $past(acc_q) + CNT_ONE)
		else $error("accumulator missed a channel 7 edge");
	capture_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
		!dir_q[CH_LO + 1] |-> ioc_oe_n[CH_LO + 1] && !cmp[CH_LO + 1])
		else $error("capture channel drove its pin");
	decode_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
		rd_go && rix == IX_DIR_SEL |=> s_axi_rvalid && s_axi_rdata[BW-1:0] == $past(dir_q))
		else $error("direction register read back wrong");
	unmapped_rd_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
		rd_go && rix >= IX_ACC_LO + IW'(1)
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unimplemented offset answered");
	reset_state_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		$rose(aresetn) |-> cnt_q == CNT_RST && dir_q == RST8 && !irq)
		else $error("state not at reset value");
endmodule

/* sim/tcc_pin_model.sv */
// tcc_pin_model: far side of the timer pins, drives pulses and sees driven pins
// assumes one clock shared with the timer; levels change just after a rising edge
`timescale 1ns/1ps
module tcc_pin_model
	import tcc_pkg::*;
(
	// clock
	input logic aclk,
	// pins from the timer
	input logic [7:0] ioc_out,
	input logic [7:0] ioc_oe_n,
	// pins into the timer
	output logic [7:0] ioc_in
);
	logic [7:0] drv_q = 8'h00;

	// the timer wins where it drives, else the far side's level
	assign ioc_in = (~ioc_oe_n & ioc_out) | (ioc_oe_n & drv_q);

	// n full pulses on one pin, each level held four cycles
	task automatic pulse(input int ch, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge aclk);
			drv_q <= drv_q | (8'h01 << ch);
			repeat (4) @(posedge aclk);
			drv_q <= drv_q & ~(8'h01 << ch);
		end
	endtask
endmodule

/* sim/six_channel_capture_compare_timer_tb.sv */
// six_channel_capture_compare_timer_tb: bus, mode and pin scenarios for tcc_top
// assumes tcc_top and the pin model share one 200 MHz clock
`timescale 1ns/1ps
module six_channel_capture_compare_timer_tb
	import tcc_pkg::*;
();
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [SW-1:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic stop_mode = 1'b0, freeze_mode = 1'b0, wait_mode = 1'b0, test_mode = 1'b0;
	logic [7:0] ioc_in, ioc_out, ioc_oe_n;
	logic irq;
	int errors = 0, total_checks = 0, cycles = 0;

	tcc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .stop_mode, .freeze_mode, .wait_mode, .test_mode, .ioc_in,
		.ioc_out, .ioc_oe_n, .irq);
	tcc_pin_model i_pins (.aclk, .ioc_out, .ioc_oe_n, .ioc_in);

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one write; address and data offered together, each released when taken
	task automatic wr(input logic [IW-1:0] ix, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {ix, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [IW-1:0] ix, output logic [7:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {ix, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic wrc(input logic [IW-1:0] ix, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		wr(ix, d, r);
		chk(r, er);
	endtask

	task automatic rdc(input logic [IW-1:0] ix, input logic [7:0] ed, input logic [1:0] er);
		logic [7:0] d;
		logic [1:0] r;
		rd(ix, d, r);
		chk(d, ed);
		chk(r, er);
	endtask

	// counter advance between two back-to-back reads of the low byte
	task automatic delta(output logic [7:0] n);
		logic [7:0] a, b;
		logic [1:0] r;
		rd(IX_CNT_LO, a, r);
		rd(IX_CNT_LO, b, r);
		n = b - a;
	endtask

	task automatic t_reset();
		chk(ioc_oe_n, 8'hff);
		chk(ioc_out, 8'h00);
		chk(irq, 1'b0);
		for (int i = 0; i < 36; i++)
			if (i < 16 || i > 19)
				rdc(i[IW-1:0], 8'h00, RESP_OKAY);
	endtask

	task automatic t_map();
		logic [IW-1:0] ux [4] = '{6'h10, 6'h13, 6'h24, 6'h2f};
		logic [IW-1:0] dx [5] = '{IX_DIR_SEL, IX_FORCE, IX_SYS1, IX_SYS2, IX_ACC_CTL};
		logic [7:0] dv [5] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'h81};
		logic [7:0] de [5] = '{8'hfc, 8'h00, 8'h70, 8'h0f, 8'h01};
		for (int i = 0; i < 4; i++) begin
			wrc(ux[i], 8'hff, RESP_SLVERR);
			rdc(ux[i], 8'h00, RESP_SLVERR);
		end
		for (int i = 0; i < 5; i++) begin
			wrc(dx[i], dv[i], RESP_OKAY);
			rdc(dx[i], de[i], RESP_OKAY);
			wrc(dx[i], 8'h00, RESP_OKAY);
		end
	endtask

	task automatic t_modes();
		logic [7:0] ms [8] = '{8'h80, 8'ha0, 8'ha0, 8'hc0, 8'h80, 8'h80, 8'h80, 8'h00};
		logic [2:0] mf [8] = '{3'h4, 3'h4, 3'h0, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0};
		logic [7:0] mr [8] = '{8'h03, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00};
		logic [7:0] n;
		for (int i = 0; i < 8; i++) begin
			{freeze_mode, wait_mode, stop_mode} <= mf[i];
			wrc(IX_SYS1, ms[i], RESP_OKAY);
			delta(n);
			chk(n, mr[i]);
		end
		{freeze_mode, wait_mode, stop_mode} <= 3'h0;
	endtask

	task automatic t_compare();
		test_mode <= 1'b1;
		wrc(IX_CNT_HI, 8'h00, RESP_OKAY);
		wrc(IX_CNT_LO, 8'h00, RESP_OKAY);
		test_mode <= 1'b0;
		wrc(IX_TC_FIRST, 8'h00, RESP_OKAY);
		wrc(IX_TC_FIRST + 6'h01, 8'h40, RESP_OKAY);
		wrc(IX_OACT_LO, 8'h30, RESP_OKAY);
		wrc(IX_DIR_SEL, 8'h04, RESP_OKAY);
		wrc(IX_IRQ_EN, 8'h04, RESP_OKAY);
		chk(ioc_oe_n, 8'hfb);
		chk(ioc_out, 8'h00);
		wrc(IX_SYS1, 8'h80, RESP_OKAY);
		for (int i = 0; i < 200 && ioc_out[2] !== 1'b1; i++)
			@(posedge aclk);
		chk(ioc_out, 8'h04);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		rdc(IX_CH_FLG, 8'h04, RESP_OKAY);
		wrc(IX_IRQ_EN, 8'h00, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		wrc(IX_CH_FLG, 8'h04, RESP_OKAY);
		wrc(IX_IRQ_EN, 8'h04, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		rdc(IX_CH_FLG, 8'h00, RESP_OKAY);
	endtask

	task automatic t_capture();
		wrc(IX_EDGE_LO, 8'h40, RESP_OKAY);
		i_pins.pulse(3, 1);
		repeat (6) @(posedge aclk);
		chk(ioc_oe_n[3], 1'b1);
		rdc(IX_CH_FLG, 8'h08, RESP_OKAY);
		wrc(IX_CH_FLG, 8'h08, RESP_OKAY);
	endtask

	task automatic t_accum();
		wrc(IX_ACC_CTL, 8'h50, RESP_OKAY);
		i_pins.pulse(7, 5);
		repeat (6) @(posedge aclk);
		chk(ioc_oe_n[7], 1'b1);
		rdc(IX_ACC_HI, 8'h00, RESP_OKAY);
		rdc(IX_ACC_LO, 8'h05, RESP_OKAY);
		rdc(IX_ACC_FLG, 8'h01, RESP_OKAY);
		chk(irq, 1'b0);
	endtask

	// forced toggle on channel 2, then a forced channel 7 event copying mask/data
	task automatic t_force();
		wrc(IX_OACT_LO, 8'h10, RESP_OKAY);
		wrc(IX_FORCE, 8'h04, RESP_OKAY);
		chk(ioc_out, 8'h00);
		wrc(IX_C7_MASK, 8'h04, RESP_OKAY);
		wrc(IX_C7_DATA, 8'h04, RESP_OKAY);
		wrc(IX_DIR_SEL, 8'h84, RESP_OKAY);
		wrc(IX_FORCE, 8'h80, RESP_OKAY);
		chk(ioc_out, 8'h04);
		chk(ioc_oe_n, 8'hfb);
		rdc(IX_CH_FLG, 8'h00, RESP_OKAY);
	endtask

	// counter wraps from a test-mode preset; overflow flag and its interrupt
	task automatic t_ovf();
		test_mode <= 1'b1;
		wrc(IX_CNT_HI, 8'hff, RESP_OKAY);
		wrc(IX_CNT_LO, 8'hf0, RESP_OKAY);
		test_mode <= 1'b0;
		repeat (24) @(posedge aclk);
		rdc(IX_OVF_FLG, 8'h80, RESP_OKAY);
		wrc(IX_SYS2, 8'h80, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		wrc(IX_OVF_FLG, 8'h80, RESP_OKAY);
		wrc(IX_SYS2, 8'h00, RESP_OKAY);
		rdc(IX_OVF_FLG, 8'h00, RESP_OKAY);
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_map();
		t_modes();
		t_compare();
		t_capture();
		t_accum();
		t_force();
		t_ovf();
		finish_test();
	end
endmodule
